// ### pac_port_a.sv
// Port A configuration block: eight configurable pins behind an APB slave.
// Assumes APB master on pclk; pin inputs already synchronous to pclk.
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps

`include "pac_map.svh"

module pac_port_a
   import pac_pkg::*;
(
   // APB clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Pins
   input  wire logic [7:0]  pin_in,
   output logic      [7:0]  pin_out,
   output logic      [7:0]  pin_oe,
   // Internal blocks
   input  wire pac_sfout_s  sf_out,
   input  wire pac_clk_sel_e clk_sel,
   input  wire logic        msel_gen2,
   input  wire pac_addr_multiplex_out_s   addr_multiplex_out,
   output pac_sfin_s        sf_in
);

   // ==========================================================
   // Configuration registers
   logic [7:0] fsel_reg;
   logic [7:0] dir_reg;
   logic [7:0] data_reg;
   logic [7:0] fsel_next;
   logic [7:0] dir_next;
   logic [7:0] data_next;

   // ==========================================================
   // Bus decode
   wire logic        hit;
   wire logic        setup;
   wire logic        wr_en;
   wire logic        rd_en;
   wire logic [7:0]  gp_out;
   wire logic [7:0]  rd_data_bits;
   wire logic [31:0] rd_word;

   assign hit   = (paddr & `PAC_ADDR_LSB_MASK) == (`PAC_CONFIG_ADDR & `PAC_ADDR_LSB_MASK);
   assign setup = psel & ~penable;
   assign wr_en = setup & pwrite & hit;
   assign rd_en = setup & ~pwrite & hit;

   // Pins currently general-purpose outputs
   assign gp_out = ~fsel_reg & dir_reg;

   // Data readback chooses stored value or pin level
   assign rd_data_bits = (gp_out & data_reg) | (~gp_out & pin_in);
   assign rd_word = {fsel_reg, dir_reg, 8'h00, rd_data_bits};

   // Next register values with byte strobes
   assign fsel_next = (wr_en & pstrb[3]) ? pwdata[`PAC_FSEL_HI:`PAC_FSEL_LO] : fsel_reg;
   assign dir_next  = (wr_en & pstrb[2]) ? pwdata[`PAC_DIR_HI:`PAC_DIR_LO] : dir_reg;
   // Only bits in general-purpose output take the written data
   assign data_next = (wr_en & pstrb[0])
                    ? ((pwdata[`PAC_DATA_HI:`PAC_DATA_LO] & gp_out) | (data_reg & ~gp_out))
                    : data_reg;

   // Configuration storage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fsel_reg <= `PAC_FSEL_RST;
         dir_reg  <= `PAC_DIR_RST;
         data_reg <= `PAC_DATA_RST;
      end
      else
      begin
         fsel_reg <= fsel_next;
         dir_reg  <= dir_next;
         data_reg <= data_next;
      end
   end

   // APB answer: ready one cycle after setup, error on unmapped address
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup & ~hit;
         prdata  <= rd_en ? rd_word : 32'h00000000;
      end
   end

   // ==========================================================
   // Special output selection per pin
   logic [7:0] sf_val;
   logic [7:0] sf_ok;
   wire logic  clk_pin_val;
   wire logic  msel_pin_val;

   assign clk_pin_val = (clk_sel == pac_clk_spi_master) ? sf_out.serial_a_spi_master_clock :
                        (clk_sel == pac_clk_gen_out1)   ? sf_out.serial_a_gen_output_1 :
                                                          sf_out.serial_a_rx_clock;
   assign msel_pin_val = msel_gen2 ? sf_out.serial_a_gen_output_2
                                   : sf_out.serial_a_spi_master_select_n;

   // Table of special outputs, pin 7 first
   assign sf_val = {sf_out.serial_a_transmit,
                    sf_out.serial_a_terminal_ready_n,
                    sf_out.serial_a_request_send_n,
                    clk_pin_val,
                    sf_out.dma_chan1_ack_out,
                    1'b0,
                    sf_out.dma_chan1_done_out_n,
                    msel_pin_val};
   // Pin 2 special output exists only via the memory module override
   assign sf_ok  = 8'hFB;

   // Internal input routing, independent of configuration
   logic [7:0] pin_out_w;
   logic [7:0] pin_oe_w;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sf_in <= '0;
      else
         sf_in <= {pin_in[6], pin_in[4], pin_in[4], pin_in[4], pin_in[3], pin_in[2],
                   pin_in[1], pin_in[0], pin_in[0], pin_in[0], pin_in[0]};
   end

   // ==========================================================
   // Pin cells
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_pin
         pac_pin_cell u_cell (
            .pclk      (pclk),
            .presetn   (presetn),
            .fsel      (fsel_next[gi]),
            .dir       (dir_next[gi]),
            .data      (data_next[gi]),
            .sf_out    (sf_val[gi]),
            .sf_valid  (sf_ok[gi]),
            .ovr_en    ((gi == `PAC_PIN_ADDR_MULTIPLEX_OUT) ? addr_multiplex_out.enable : 1'b0),
            .ovr_level ((gi == `PAC_PIN_ADDR_MULTIPLEX_OUT) ? addr_multiplex_out.level : 1'b0),
            .pin_out   (pin_out_w[gi]),
            .pin_oe    (pin_oe_w[gi])
         );
      end
   endgenerate

   assign pin_out = pin_out_w;
   assign pin_oe  = pin_oe_w;

   // ==========================================================
   // Checks
   chk_gpout_drive: assert property (@(posedge pclk) disable iff (!presetn)
      (~fsel_reg[5] & dir_reg[5] & ~$past(wr_en)) |-> pin_out[5] == data_reg[5])
      else $error("gp output pin not driving stored data");
   chk_data_protect: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en & ~gp_out[1]) |=> data_reg[1] == $past(data_reg[1]))
      else $error("data bit changed while not gp output");
   chk_read_stored: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_en & gp_out[6]) |=> prdata[6] == $past(data_reg[6]))
      else $error("gp output readback not stored value");
   chk_read_pin: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_en & ~gp_out[3]) |=> prdata[3] == $past(pin_in[3]))
      else $error("readback not pin level");
   chk_oe_input: assert property (@(posedge pclk) disable iff (!presetn)
      (~dir_reg[7] & ~$past(wr_en)) |-> ~pin_oe[7])
      else $error("driver on for input pin");
   chk_addr_multiplex_out_over: assert property (@(posedge pclk) disable iff (!presetn)
      $past(addr_multiplex_out.enable) |-> pin_oe[2] && pin_out[2] == $past(addr_multiplex_out.level))
      else $error("address multiplex did not override pin");
   chk_clk_pin: assert property (@(posedge pclk) disable iff (!presetn)
      (fsel_next[4] & dir_next[4] & clk_sel == pac_clk_gen_out1)
      |=> pin_out[4] == $past(sf_out.serial_a_gen_output_1))
      else $error("pin 4 special output wrong");
   chk_sel_pin: assert property (@(posedge pclk) disable iff (!presetn)
      (fsel_next[0] & dir_next[0] & ~msel_gen2)
      |=> pin_out[0] == $past(sf_out.serial_a_spi_master_select_n))
      else $error("pin 0 special output wrong");
   chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
      $past(rd_en) |-> prdata[15:8] == 8'h00 && pready)
      else $error("reserved bits nonzero");
   chk_route_in: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> sf_in.serial_a_receive == $past(pin_in[3]))
      else $error("input routing broken");

   cov_write: cover property (@(posedge pclk) disable iff (!presetn) wr_en ##1 pready);
   cov_read_gp: cover property (@(posedge pclk) disable iff (!presetn) rd_en & gp_out[0]);
   cov_addr_multiplex_out: cover property (@(posedge pclk) disable iff (!presetn) addr_multiplex_out.enable);
   cov_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule

// ### pac_map.svh
// Register map and field positions of the port A configuration block.
// Assumes inclusion by the design modules by bare name.
`ifndef PAC_MAP_SVH
`define PAC_MAP_SVH

// ==========================================================
// Register offsets
`define PAC_CONFIG_ADDR   32'hFFB00020
`define PAC_ADDR_LSB_MASK 32'h00000FFF

// ==========================================================
// Field positions
`define PAC_FSEL_HI       31
`define PAC_FSEL_LO       24
`define PAC_DIR_HI        23
`define PAC_DIR_LO        16
`define PAC_DATA_HI       7
`define PAC_DATA_LO       0

// ==========================================================
// Reset values
`define PAC_FSEL_RST      8'h00
`define PAC_DIR_RST       8'h00
`define PAC_DATA_RST      8'h00

// ==========================================================
// Pin numbers with special roles
`define PAC_PIN_MCLK      4
`define PAC_PIN_ADDR_MULTIPLEX_OUT      2
`define PAC_PIN_MSEL      0

`endif

// ### pac_pkg.sv
// Types shared by the port A configuration block.
// Assumes pac_map.svh is present in the same folder.
package pac_pkg;

   // ==========================================================
   // Pin selection for the shared clock pin (pin 4)
   typedef enum logic [1:0] {
      pac_clk_spi_master,
      pac_clk_gen_out1,
      pac_clk_rx_clock
   } pac_clk_sel_e;

   // Special outputs presented to the port by the internal blocks
   typedef struct packed {
      logic serial_a_transmit;
      logic serial_a_terminal_ready_n;
      logic serial_a_request_send_n;
      logic serial_a_spi_master_clock;
      logic serial_a_gen_output_1;
      logic serial_a_rx_clock;
      logic dma_chan1_ack_out;
      logic dma_chan1_done_out_n;
      logic serial_a_spi_master_select_n;
      logic serial_a_gen_output_2;
   } pac_sfout_s;

   // Pin levels routed to internal inputs
   typedef struct packed {
      logic dma_chan1_request_in;
      logic serial_a_ring_n;
      logic serial_a_rx_clock_in;
      logic serial_a_spi_slave_clock;
      logic serial_a_receive;
      logic serial_a_set_ready_n;
      logic serial_a_clear_send;
      logic serial_a_spi_slave_select_n;
      logic serial_a_carrier_detect_n;
      logic dma_chan1_done_in_n;
      logic serial_a_tx_clock;
   } pac_sfin_s;

   // Memory module control of the address multiplex pin
   typedef struct packed {
      logic enable;
      logic level;
   } pac_addr_multiplex_out_s;

endpackage

// ### pac_pin_cell.sv
// One pin cell of port A: output selection and driver enable.
// Assumes configuration bits are the parent's next-state values, registered here with the drive.
`timescale 1ns/10ps

`include "pac_map.svh"

module pac_pin_cell
   import pac_pkg::*;
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Configuration of this pin
   input  wire logic fsel,
   input  wire logic dir,
   input  wire logic data,
   // Special output value and whether it exists
   input  wire logic sf_out,
   input  wire logic sf_valid,
   // Override by the memory module
   input  wire logic ovr_en,
   input  wire logic ovr_level,
   // Registered pin drive
   output logic      pin_out,
   output logic      pin_oe
);

   // ==========================================================
   // Next drive values
   wire logic out_next;
   wire logic oe_next;

   assign out_next = ovr_en ? ovr_level : (fsel ? sf_out : data);
   assign oe_next  = ovr_en | (dir & (~fsel | sf_valid));

   // Driver flip-flops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end
      else
      begin
         pin_out <= out_next;
         pin_oe  <= oe_next;
      end
   end

endmodule

// ### pac_ext_model.sv
// Outside circuit on the port A pins.
// Assumes the port drives pin_out where pin_oe is high.
`timescale 1ns/10ps

module pac_ext_model
(
   // Device drive
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   // Level the outside circuit wants
   input  wire logic [7:0] ext_level,
   // Resolved pin level
   output logic      [7:0] pin_in
);
   // Outside drives only where the device driver is off
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ### pac_port_a_bench.sv
// Self-checking bench of the port A configuration block.
// Assumes pac_pkg and the design modules are compiled first.
`timescale 1ns/10ps

module pac_port_a_bench;
   import pac_pkg::*;
   // ==========================================================
   // Signals
   logic         pclk, presetn, psel, penable, pwrite, msel_gen2, last_err;
   logic [31:0]  paddr, pwdata, prdata, rd;
   logic [3:0]   pstrb;
   logic         pready, pslverr;
   logic [7:0]   pin_in, pin_out, pin_oe, ext;
   pac_sfout_s   sf_out;
   pac_clk_sel_e clk_sel;
   pac_addr_multiplex_out_s    addr_multiplex_out;
   pac_sfin_s    sf_in;
   int           err_total, n_tests;

   pac_port_a pac_port_a_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .sf_out(sf_out),
      .clk_sel(clk_sel), .msel_gen2(msel_gen2), .addr_multiplex_out(addr_multiplex_out), .sf_in(sf_in));
   pac_ext_model pac_ext_model_inst (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_level(ext), .pin_in(pin_in));

   // Clock
   always #50 pclk = ~pclk;

   // ==========================================================
   // Helpers
   task stop_test;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // One APB transfer, held until pready is sampled high
   task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // Look at the answer mid-cycle, where it has settled
      @(negedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(negedge pclk);
         n++;
      end
      rd       = prdata;
      last_err = pslverr;
      // Edge at which pready is sampled high; release only after it
      @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         err_total++;
         $display("[FAIL] apb_ready exp 1 seen 0");
      end
   endtask

   // ==========================================================
   // Scenarios
   task t_reset;
      apb(1'b0, 32'hFFB00020, 32'h0);
      chk("rst_reg", 32'h0, rd);
      chk("rst_oe", 8'h00, pin_oe);
      $display("test reset done");
   endtask

   task t_gpio;
      ext <= 8'h0F;
      // Make the pins outputs first; data writes follow the old setup
      apb(1'b1, 32'hFFB00020, 32'h00FF0000);
      apb(1'b1, 32'hFFB00020, 32'h00FFFFA5);
      chk("gp_oe", 8'hFF, pin_oe);
      chk("gp_out", 8'hA5, pin_out);
      apb(1'b0, 32'hFFB00020, 32'h0);
      chk("gp_rd", 32'h00FF00A5, rd);
      apb(1'b1, 32'hFFB00020, 32'h008000FF);
      chk("dir_oe", 8'h80, pin_oe);
      apb(1'b0, 32'hFFB00020, 32'h0);
      chk("mix_rd", 32'h0080008F, rd);
      apb(1'b1, 32'hFFB00020, 32'h00800000);
      apb(1'b1, 32'hFFB00020, 32'h00FF0000);
      chk("in_wr", 8'h7F, pin_out);
      $display("test gpio done");
   endtask

   task t_special;
      logic [2:0] oh;
      sf_out <= 10'b1010001000;
      apb(1'b1, 32'hFFB00020, 32'hFFFF0000);
      cyc(2);
      chk("sf_oe", 8'hFB, pin_oe & 8'hFB);
      chk("sf_out", 8'hA8, pin_out & 8'hEA);
      for (int i = 0; i < 6; i++)
      begin
         oh = 3'b100 >> (i % 3);
         if (i > 2)
            oh = ~oh;
         clk_sel <= pac_clk_sel_e'(i % 3);
         sf_out.serial_a_spi_master_clock <= oh[2];
         sf_out.serial_a_gen_output_1 <= oh[1];
         sf_out.serial_a_rx_clock <= oh[0];
         cyc(2);
         chk("clk_pin", (i < 3), pin_out[4]);
      end
      for (int i = 0; i < 2; i++)
      begin
         msel_gen2 <= i[0];
         sf_out.serial_a_spi_master_select_n <= 1'b1;
         sf_out.serial_a_gen_output_2 <= 1'b0;
         cyc(2);
         chk("msel_pin", !i[0], pin_out[0]);
      end
      $display("test special done");
   endtask

   task t_addr_multiplex_out;
      apb(1'b1, 32'hFFB00020, 32'h0);
      for (int i = 0; i < 2; i++)
      begin
         addr_multiplex_out <= '{1'b1, i[0]};
         cyc(2);
         chk("addr_multiplex_out", {1'b1, i[0]}, {pin_oe[2], pin_out[2]});
      end
      addr_multiplex_out <= '{1'b0, 1'b0};
      cyc(2);
      chk("addr_multiplex_out_off", 1'b0, pin_oe[2]);
      $display("test addr_multiplex_out done");
   endtask

   task t_route;
      for (int i = 0; i < 2; i++)
      begin
         ext <= i ? 8'hA5 : 8'h5A;
         cyc(3);
         chk("route", {ext[6], {3{ext[4]}}, ext[3:0], {3{ext[0]}}}, sf_in);
      end
      $display("test route done");
   endtask

   task t_unmapped;
      apb(1'b1, 32'hFFB00024, 32'hFFFF00FF);
      chk("slverr", 1'b1, last_err);
      apb(1'b0, 32'hFFB00020, 32'h0);
      chk("kept", 32'h0, rd & 32'hFFFF0000);
      $display("test unmapped done");
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      {pclk, presetn, psel, penable, pwrite, msel_gen2} = '0;
      {paddr, pwdata, ext, err_total, n_tests} = '0;
      pstrb   = 4'hF;
      sf_out  = '0;
      clk_sel = pac_clk_spi_master;
      addr_multiplex_out    = '0;
      cyc(2);
      presetn <= 1'b1;
      t_reset;
      t_gpio;
      t_special;
      t_addr_multiplex_out;
      t_route;
      t_unmapped;
      stop_test;
   end

   // Watchdog
   initial
   begin
      #(2000 * 100);
      err_total++;
      stop_test;
   end
endmodule
